//--- common/serial2_pkg.sv
package serial2_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [4:0] OFF_MCR     = 5'h00;
    localparam logic [4:0] OFF_MSR     = 5'h04;
    localparam logic [4:0] OFF_CFG     = 5'h08;
    localparam logic [4:0] OFF_GPIO    = 5'h0c;
    localparam logic [4:0] OFF_IRQ_ST  = 5'h10;
    localparam logic [4:0] OFF_IRQ_MSK = 5'h14;
    localparam logic [4:0] OFF_STRAP   = 5'h18;

    // Modem control fields
    localparam int MCR_DTR  = 0;
    localparam int MCR_RTS  = 1;
    localparam int MCR_LOOP = 4;

    // Modem status fields
    localparam int MSR_DCTS = 0;
    localparam int MSR_DDSR = 1;
    localparam int MSR_TERI = 2;
    localparam int MSR_CTS  = 4;
    localparam int MSR_DSR  = 5;
    localparam int MSR_RI   = 6;

    // Config fields: bits 3..0 pick general purpose use per shared pin
    localparam int CFG_IR = 4;

    // Event positions in status, mask and change detector
    localparam int EV_CTS  = 0;
    localparam int EV_DSR  = 1;
    localparam int EV_RING = 2;

    // Reset values
    localparam logic [7:0] MCR_RST  = 8'h00;
    localparam logic [7:0] CFG_RST  = 8'h00;
    localparam logic [7:0] GPIO_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;

    // The four pins shared with general purpose port 6, bit 0 is the serial input
    typedef struct packed {
        logic port2_ring_n;
        logic port2_send_clear_n;
        logic port2_set_ready_n;
        logic port2_serial_in;
    } quad_s;

    // Output and enable of one output pin that doubles as a strap input
    typedef struct packed {
        logic o;
        logic oe;
    } drive_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [7:0]  modem_control_reg;
        logic [7:0]  cfg;
        logic [7:0]  gpio;
        logic [7:0]  ist;
        logic [7:0]  imask;
        logic        irq;
        drive_s      sout;
        drive_s      rts;
        drive_s      dtr;
        logic        rxd;
        logic [2:0]  strap;
        logic        pgood_prev;
    } top_state_s;

    localparam top_state_s TOP_RST = '{
        ack: 1'b0, dat: 32'h0000_0000, modem_control_reg: MCR_RST, cfg: CFG_RST,
        gpio: GPIO_RST, ist: 8'h00, imask: MASK_RST, irq: 1'b0,
        sout: '{o: 1'b1, oe: 1'b0}, rts: '{o: 1'b1, oe: 1'b0},
        dtr: '{o: 1'b1, oe: 1'b0}, rxd: 1'b1, strap: 3'h0,
        pgood_prev: 1'b0};

    typedef struct packed {
        quad_s o;
        quad_s oe;
        quad_s view;
        quad_s raw;
    } mux_state_s;

    typedef struct packed {
        logic       primed;
        logic [2:0] prev;
    } chg_state_s;

endpackage

//--- design/modem_change_detect.sv
`timescale 1ns/1ps
`default_nettype none
module modem_change_detect (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [2:0] lvl,
    output logic      [2:0] ev
);
    serial2_pkg::chg_state_s st_ff;
    serial2_pkg::chg_state_s nxt_st;

    // Primed bit stops a false event on the first sample after reset
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.prev = lvl;
        nxt_st.primed = 1'b1;
        ev = '0;
        if (st_ff.primed)
        begin
            ev[serial2_pkg::EV_CTS] = lvl[0] ^ st_ff.prev[0];
            ev[serial2_pkg::EV_DSR] = lvl[1] ^ st_ff.prev[1];
            ev[serial2_pkg::EV_RING] = lvl[2] & ~st_ff.prev[2];
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end
endmodule
`default_nettype wire

//--- design/port6_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module port6_pin_mux (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic         [3:0] gp_sel,
    input  wire logic         [3:0] gp_out,
    input  wire logic         [3:0] gp_oe,
    input  wire serial2_pkg::quad_s pins_i,
    output serial2_pkg::quad_s      pins_o,
    output serial2_pkg::quad_s      pins_oe,
    output serial2_pkg::quad_s      view,
    output serial2_pkg::quad_s      raw
);
    serial2_pkg::mux_state_s st_ff;
    serial2_pkg::mux_state_s nxt_st;

    // Port side sees an idle high level on any pin lent to general purpose use
    always_comb
    begin
        nxt_st.o = gp_out;
        nxt_st.oe = gp_oe & gp_sel;
        nxt_st.view = pins_i | gp_sel;
        nxt_st.raw = pins_i;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_ff <= '{o: 4'h0, oe: 4'h0, view: 4'hf, raw: 4'hf};
        else
            st_ff <= nxt_st;
    end

    assign pins_o = st_ff.o;
    assign pins_oe = st_ff.oe;
    assign view = st_ff.view;
    assign raw = st_ff.raw;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_sin_gpio_idle: assert property ($past(gp_sel[0]) |-> view.port2_serial_in)
        else $error("serial input not idle while lent to gpio");
    a_sin_pass: assert property (!$past(gp_sel[0]) |-> view[0] == $past(pins_i[0]))
        else $error("serial input not passed through");
    a_gp_drive: assert property (gp_sel[1] && gp_oe[1] |=> pins_oe[1] && pins_o[1] == $past(gp_out[1]))
        else $error("gpio drive lost on status pin");
    a_status_idle: assert property (|gp_sel[3:1] |=> (view[3:1] & $past(gp_sel[3:1])) == $past(gp_sel[3:1]))
        else $error("status seen active while lent to gpio");
    a_no_drive: assert property (!gp_sel[2] |=> !pins_oe[2])
        else $error("status pin driven in modem use");
endmodule
`default_nettype wire

//--- design/serial_port_two_modem_pins.sv
// Summary of operation
// - Serial output marks high after reset until the core starts sending.
// - Infrared mode holds the wired serial output at the marking level.
// - Control bit set to one drives send request low.
// - Send request is high after reset and throughout loopback.
// - Control bit set to one drives terminal ready low.
// - Terminal ready is high after reset and throughout loopback.
// - Modem drives set ready low; its state reads in modem status.
// - Modem drives send clear low; its state reads in modem status.
// - Modem pulls ring low on a ring; its state reads in modem status.
// - During bus reset the send request pin is an input, caught as strap.
// - During bus reset the terminal ready pin is an input, caught as strap.
// - Serial output pin is sampled as strap when power good rises.
// - Serial input serves the port or general purpose port 6 bit 3.
// - Set ready, send clear, ring serve alternatively as port 6 bits 4-6.
`timescale 1ns/1ps
`default_nettype none
module serial_port_two_modem_pins (
    input  wire logic               clock,
    input  wire logic               rst,
    input  wire logic         [4:0] wb_adr_i,
    input  wire logic        [31:0] wb_dat_i,
    output logic             [31:0] wb_dat_o,
    input  wire logic               wb_we_i,
    input  wire logic         [3:0] wb_sel_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic                    wb_ack_o,
    output logic                    irq,
    input  wire logic               bus_reset_n,
    input  wire logic               power_good,
    input  wire logic               core_txd,
    output logic                    core_rxd,
    output logic                    core_cts_n,
    output logic                    core_dsr_n,
    output logic                    core_ring_n,
    input  wire serial2_pkg::quad_s shared_i,
    output serial2_pkg::quad_s      shared_o,
    output serial2_pkg::quad_s      shared_oe,
    input  wire logic               port2_serial_out_i,
    output logic                    port2_serial_out_o,
    output logic                    port2_serial_out_oe,
    input  wire logic               port2_send_request_n_i,
    output logic                    port2_send_request_n_o,
    output logic                    port2_send_request_n_oe,
    input  wire logic               port2_terminal_ready_n_i,
    output logic                    port2_terminal_ready_n_o,
    output logic                    port2_terminal_ready_n_oe,
    output logic                    strap_option_four,
    output logic                    strap_option_five,
    output logic                    strap_option_six
);
    serial2_pkg::top_state_s st_ff;
    serial2_pkg::top_state_s nxt_st;
    serial2_pkg::quad_s      view;
    serial2_pkg::quad_s      raw;
    logic              [2:0] msr_lvl;
    logic              [2:0] events;
    logic                    req;
    logic                    wr;
    logic                    loop;
    logic              [7:0] clr;

    // Word decode ignores the byte lane bits of the address
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return a[4:2] == off[4:2];
    endfunction

    // One request per ack; the idle cycle after ack stops a double take
    assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign loop = st_ff.modem_control_reg[serial2_pkg::MCR_LOOP];

    port6_pin_mux u_mux (
        .clock   (clock),
        .rst     (rst),
        .gp_sel  (st_ff.cfg[3:0]),
        .gp_out  (st_ff.gpio[3:0]),
        .gp_oe   (st_ff.gpio[7:4]),
        .pins_i  (shared_i),
        .pins_o  (shared_o),
        .pins_oe (shared_oe),
        .view    (view),
        .raw     (raw)
    );

    // Active high modem levels; loopback feeds the control bits back
    always_comb
    begin
        if (loop)
        begin
            msr_lvl[0] = st_ff.modem_control_reg[serial2_pkg::MCR_RTS];
            msr_lvl[1] = st_ff.modem_control_reg[serial2_pkg::MCR_DTR];
            msr_lvl[2] = 1'b0;
        end
        else
        begin
            msr_lvl[0] = ~view.port2_send_clear_n;
            msr_lvl[1] = ~view.port2_set_ready_n;
            msr_lvl[2] = ~view.port2_ring_n;
        end
    end

    modem_change_detect u_chg (
        .clock (clock),
        .rst   (rst),
        .lvl   (msr_lvl),
        .ev    (events)
    );

    // Register file, pin drive and strap capture
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.dat = 32'h0000_0000;
        clr = 8'h00;
        if (req && !wb_we_i)
        begin
            if (hit(wb_adr_i, serial2_pkg::OFF_MCR))
                nxt_st.dat[7:0] = st_ff.modem_control_reg;
            else if (hit(wb_adr_i, serial2_pkg::OFF_MSR))
            begin
                nxt_st.dat[serial2_pkg::MSR_DSR] = msr_lvl[1];
                nxt_st.dat[serial2_pkg::MSR_CTS] = msr_lvl[0];
                nxt_st.dat[serial2_pkg::MSR_RI] = msr_lvl[2];
                nxt_st.dat[serial2_pkg::MSR_DCTS] = st_ff.ist[serial2_pkg::EV_CTS];
                nxt_st.dat[serial2_pkg::MSR_DDSR] = st_ff.ist[serial2_pkg::EV_DSR];
                nxt_st.dat[serial2_pkg::MSR_TERI] = st_ff.ist[serial2_pkg::EV_RING];
            end
            else if (hit(wb_adr_i, serial2_pkg::OFF_CFG))
                nxt_st.dat[7:0] = st_ff.cfg;
            else if (hit(wb_adr_i, serial2_pkg::OFF_GPIO))
                nxt_st.dat[11:0] = {raw, st_ff.gpio};
            else if (hit(wb_adr_i, serial2_pkg::OFF_IRQ_ST))
                nxt_st.dat[7:0] = st_ff.ist;
            else if (hit(wb_adr_i, serial2_pkg::OFF_IRQ_MSK))
                nxt_st.dat[7:0] = st_ff.imask;
            else if (hit(wb_adr_i, serial2_pkg::OFF_STRAP))
                nxt_st.dat[2:0] = st_ff.strap;
        end

        // Writes; unmapped words are acked and dropped
        if (wr)
        begin
            if (hit(wb_adr_i, serial2_pkg::OFF_MCR))
                nxt_st.modem_control_reg = wb_dat_i[7:0];
            else if (hit(wb_adr_i, serial2_pkg::OFF_CFG))
                nxt_st.cfg = wb_dat_i[7:0];
            else if (hit(wb_adr_i, serial2_pkg::OFF_GPIO))
                nxt_st.gpio = wb_dat_i[7:0];
            else if (hit(wb_adr_i, serial2_pkg::OFF_IRQ_ST))
                clr = wb_dat_i[7:0];
            else if (hit(wb_adr_i, serial2_pkg::OFF_IRQ_MSK))
                nxt_st.imask = wb_dat_i[7:0];
        end

        // Event set beats a simultaneous write-one clear
        nxt_st.ist = (st_ff.ist & ~clr) | {5'h00, events};
        nxt_st.irq = |(nxt_st.ist & nxt_st.imask);

        // marking unless the core is sending on the wire
        if (st_ff.cfg[serial2_pkg::CFG_IR] || loop)
            nxt_st.sout.o = 1'b1;
        else
            nxt_st.sout.o = core_txd;

        // strap caught at the rising edge of power good
        nxt_st.pgood_prev = power_good;
        if (power_good && !st_ff.pgood_prev)
            nxt_st.strap[2] = port2_serial_out_i;
        nxt_st.sout.oe = st_ff.pgood_prev;

        // request to send, high in loopback
        nxt_st.rts.o = ~(st_ff.modem_control_reg[serial2_pkg::MCR_RTS] & ~loop);
        nxt_st.dtr.o = ~(st_ff.modem_control_reg[serial2_pkg::MCR_DTR] & ~loop);

        // pins float and are caught while bus reset holds
        nxt_st.rts.oe = bus_reset_n;
        nxt_st.dtr.oe = bus_reset_n;
        if (!bus_reset_n)
        begin
            nxt_st.strap[1] = port2_send_request_n_i;
            nxt_st.strap[0] = port2_terminal_ready_n_i;
        end

        // loopback returns the core's own data
        nxt_st.rxd = loop ? core_txd : view.port2_serial_in;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            st_ff <= serial2_pkg::TOP_RST;
        else
            st_ff <= nxt_st;
    end

    // Outputs straight from the state register; modem lines straight from the pin mux register
    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign irq = st_ff.irq;
    assign core_rxd = st_ff.rxd;
    assign core_cts_n = view.port2_send_clear_n;
    assign core_dsr_n = view.port2_set_ready_n;
    assign core_ring_n = view.port2_ring_n;
    assign port2_serial_out_o = st_ff.sout.o;
    assign port2_serial_out_oe = st_ff.sout.oe;
    assign port2_send_request_n_o = st_ff.rts.o;
    assign port2_send_request_n_oe = st_ff.rts.oe;
    assign port2_terminal_ready_n_o = st_ff.dtr.o;
    assign port2_terminal_ready_n_oe = st_ff.dtr.oe;
    assign strap_option_four = st_ff.strap[0];
    assign strap_option_five = st_ff.strap[1];
    assign strap_option_six = st_ff.strap[2];

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Low on the wire only ever copies a low from the core
    a_sout_low_cause: assert property (!port2_serial_out_o |-> !$past(core_txd))
        else $error("serial output left marking without core data");
    a_sout_ir_mark: assert property (st_ff.cfg[serial2_pkg::CFG_IR] |=> port2_serial_out_o)
        else $error("serial output not marking in infrared mode");
    a_rts_on: assert property (
        st_ff.modem_control_reg[serial2_pkg::MCR_RTS] && !loop |=> !port2_send_request_n_o)
        else $error("send request not driven low");
    a_rts_loop: assert property (loop |=> port2_send_request_n_o)
        else $error("send request active in loopback");
    a_dtr_on: assert property (
        st_ff.modem_control_reg[serial2_pkg::MCR_DTR] && !loop |=> !port2_terminal_ready_n_o)
        else $error("terminal ready not driven low");
    a_dtr_loop: assert property (loop |=> port2_terminal_ready_n_o)
        else $error("terminal ready active in loopback");
    a_msr_dsr: assert property (
        req && !wb_we_i && hit(wb_adr_i, serial2_pkg::OFF_MSR) && !loop
        |=> wb_ack_o && wb_dat_o[serial2_pkg::MSR_DSR] == !$past(view.port2_set_ready_n))
        else $error("set ready not reflected in status");
    a_msr_cts: assert property (
        req && !wb_we_i && hit(wb_adr_i, serial2_pkg::OFF_MSR) && !loop
        |=> wb_dat_o[serial2_pkg::MSR_CTS] == !$past(view.port2_send_clear_n))
        else $error("send clear not reflected in status");
    a_ring_event: assert property (
        !loop && $fell(view.port2_ring_n) |=> st_ff.ist[serial2_pkg::EV_RING])
        else $error("ring not recorded");
    a_strap_rts: assert property (!bus_reset_n |=> strap_option_five == $past(port2_send_request_n_i))
        else $error("send request strap not caught");
    a_strap_dtr: assert property (!bus_reset_n ##1 !bus_reset_n |-> !port2_terminal_ready_n_oe)
        else $error("terminal ready driven during bus reset");
    a_strap_sout: assert property (
        power_good && !st_ff.pgood_prev |=> strap_option_six == $past(port2_serial_out_i))
        else $error("serial output strap not caught");

    c_irq_raise: cover property ($rose(irq));
    c_loop_on: cover property ($rose(loop) ##[1:20] wb_ack_o);
    c_strap_pg: cover property (power_good && !st_ff.pgood_prev);
    c_bus_reset: cover property ($rose(bus_reset_n));
endmodule
`default_nettype wire

//--- tb/modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module modem_model (
    input  wire logic          clock,
    input  wire logic          slow,
    input  wire logic    [2:0] cmd,
    input  wire logic          line_bit,
    output serial2_pkg::quad_s pins
);
    logic [3:0] stage_ff = 4'hf;
    logic [3:0] stage2_ff = 4'hf;

    // Status lines are active low; slow mode answers one cycle later
    // low when asserted
    always_ff @(posedge clock)
    begin
        stage_ff  <= {~cmd[2], ~cmd[0], ~cmd[1], line_bit};
        stage2_ff <= stage_ff;
    end

    assign pins = slow ? stage2_ff : stage_ff;
endmodule
`default_nettype wire

//--- tb/tb_serial_port_two_modem_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port_two_modem_pins;
    // Strap resistor levels seen while the pins are not driven
    localparam logic STRAP_DTR  = 1'b1;
    localparam logic STRAP_RTS  = 1'b0;
    localparam logic STRAP_SOUT = 1'b1;

    logic               clock;
    logic               rst;
    logic         [4:0] wb_adr;
    logic        [31:0] wb_dat;
    logic         [3:0] wb_sel;
    logic               wb_we;
    logic               wb_cyc;
    logic               wb_stb;
    logic        [31:0] wb_dat_o;
    logic               wb_ack_o;
    logic               irq;
    logic               bus_reset_n;
    logic               power_good;
    logic               core_txd;
    logic               core_rxd;
    logic               core_cts_n;
    logic               core_dsr_n;
    logic               core_ring_n;
    logic         [2:0] modem_cmd;
    logic               line_bit;
    logic               slow;
    serial2_pkg::quad_s modem_pins;
    serial2_pkg::quad_s shared_i;
    serial2_pkg::quad_s shared_o;
    serial2_pkg::quad_s shared_oe;
    logic               sout_o;
    logic               sout_oe;
    logic               rts_o;
    logic               rts_oe;
    logic               dtr_o;
    logic               dtr_oe;
    logic         [2:0] straps;
    logic        [31:0] q;
    int                 err_total = 0;
    int                 tests_run = 0;

    // Each wire level comes from whoever enables its driver
    assign shared_i = serial2_pkg::quad_s'((shared_oe & shared_o) | (~shared_oe & modem_pins));

    serial_port_two_modem_pins uut (
        .clock(clock), .rst(rst), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we), .wb_sel_i(wb_sel), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o), .irq(irq), .bus_reset_n(bus_reset_n),
        .power_good(power_good), .core_txd(core_txd), .core_rxd(core_rxd),
        .core_cts_n(core_cts_n), .core_dsr_n(core_dsr_n), .core_ring_n(core_ring_n),
        .shared_i(shared_i), .shared_o(shared_o), .shared_oe(shared_oe),
        .port2_serial_out_i(sout_oe ? sout_o : STRAP_SOUT),
        .port2_serial_out_o(sout_o), .port2_serial_out_oe(sout_oe),
        .port2_send_request_n_i(rts_oe ? rts_o : STRAP_RTS),
        .port2_send_request_n_o(rts_o), .port2_send_request_n_oe(rts_oe),
        .port2_terminal_ready_n_i(dtr_oe ? dtr_o : STRAP_DTR),
        .port2_terminal_ready_n_o(dtr_o), .port2_terminal_ready_n_oe(dtr_oe),
        .strap_option_four(straps[0]), .strap_option_five(straps[1]),
        .strap_option_six(straps[2])
    );

    modem_model modem (
        .clock(clock), .slow(slow), .cmd(modem_cmd), .line_bit(line_bit), .pins(modem_pins)
    );

    // Free running system clock
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d of %0d compares", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Classic cycle; ack and read data are both taken at the rising edge
    // A missing ack is left to the hang guard, which ends the run
    task automatic wb_cycle(input logic we, input logic [4:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [31:0] rd);
        @(posedge clock);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= s;
        @(posedge clock);
        while (wb_ack_o !== 1'b1)
            @(posedge clock);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] unused;
        wb_cycle(1'b1, a, d, 4'hf, unused);
    endtask

    task automatic rd_check(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0000_0000, 4'hf, q);
        check(q & mask, exp);
    endtask

    // Pins are compared mid-cycle, after the edge updates have landed
    task automatic at_neg(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    // Hang guard; the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        conclude();
    end

    initial
    begin
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} = '0;
        {bus_reset_n, power_good, modem_cmd, slow} = '0;
        core_txd = 1'b1;
        line_bit = 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        at_neg(2);
        check({rts_oe, dtr_oe}, 2'b00);
        check({rts_o, dtr_o, sout_o}, 3'b111);
        @(posedge clock);
        power_good <= 1'b1;
        @(posedge clock);
        bus_reset_n <= 1'b1;
        at_neg(3);
        check(straps, {STRAP_SOUT, STRAP_RTS, STRAP_DTR});
        check({sout_oe, rts_oe, dtr_oe}, 3'b111);
        rd_check(serial2_pkg::OFF_STRAP, 32'h7, 32'h5);
        rd_check(serial2_pkg::OFF_MCR, 32'hff, 32'h0);
        rd_check(serial2_pkg::OFF_CFG, 32'hff, 32'h0);
        rd_check(serial2_pkg::OFF_GPIO, 32'hfff, 32'hf00);
        rd_check(serial2_pkg::OFF_MSR, 32'hff, 32'h0);
        // Control bits in every combination, then a clearing write without its byte lane
        for (int v = 0; v < 4; v++)
        begin
            wr(serial2_pkg::OFF_MCR, v);
            at_neg(2);
            check({rts_o, dtr_o}, ~v & 3);
        end
        wb_cycle(1'b1, serial2_pkg::OFF_MCR, 32'h0, 4'he, q);
        wr(5'h1c, 32'hff);
        at_neg(2);
        check({rts_o, dtr_o}, 2'b00);
        rd_check(5'h1c, 32'hffff_ffff, 32'h0);
        // Loopback keeps both outputs idle even with the control bits set
        @(posedge clock);
        core_txd <= 1'b0;
        wr(serial2_pkg::OFF_MCR, 32'h13);
        at_neg(2);
        check({rts_o, dtr_o, core_rxd}, 3'b110);
        rd_check(serial2_pkg::OFF_MSR, 32'h70, 32'h30);
        wr(serial2_pkg::OFF_MCR, 32'h0);
        at_neg(2);
        check(sout_o, 1'b0);
        wr(serial2_pkg::OFF_CFG, 32'h10);
        at_neg(2);
        check(sout_o, 1'b1);
        wr(serial2_pkg::OFF_CFG, 32'h0);
        // Entering and leaving loopback both move the fed-back levels
        rd_check(serial2_pkg::OFF_IRQ_ST, 32'hff, 32'h3);
        wr(serial2_pkg::OFF_IRQ_ST, 32'h7);
        @(posedge clock);
        core_txd <= 1'b1;
        // Each status line: masked, unmasked, cleared, then released
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock);
            slow <= (i == 1);
            modem_cmd <= 3'(1 << i);
            at_neg(4);
            check({core_ring_n, core_dsr_n, core_cts_n}, ~(1 << i) & 7);
            rd_check(serial2_pkg::OFF_MSR, 32'h77, (1 << (4 + i)) | (1 << i));
            check(irq, 1'b0);
            wr(serial2_pkg::OFF_IRQ_MSK, 1 << i);
            at_neg(2);
            check(irq, 1'b1);
            wr(serial2_pkg::OFF_IRQ_ST, 1 << i);
            at_neg(2);
            check(irq, 1'b0);
            @(posedge clock);
            modem_cmd <= 3'b000;
            at_neg(4);
            rd_check(serial2_pkg::OFF_IRQ_ST, 32'hff, (i == 2) ? 0 : (1 << i));
            wr(serial2_pkg::OFF_IRQ_ST, 32'h7);
            wr(serial2_pkg::OFF_IRQ_MSK, 32'h0);
        end
        // Lend each shared pin: the port sees it idle, the bit reads raw and drives
        for (int i = 0; i < 4; i++)
        begin
            wr(serial2_pkg::OFF_CFG, 1 << i);
            @(posedge clock);
            line_bit <= (i != 0);
            modem_cmd <= (i == 1) ? 3'b010 : (i == 2) ? 3'b001 : (i == 3) ? 3'b100 : 3'b000;
            at_neg(4);
            check({core_ring_n, core_cts_n, core_dsr_n, core_rxd}, 4'hf);
            rd_check(serial2_pkg::OFF_GPIO, 32'hfff, (~(1 << i) & 15) << 8);
            @(posedge clock);
            line_bit <= 1'b1;
            modem_cmd <= 3'b000;
            wr(serial2_pkg::OFF_GPIO, (1 << (i + 4)) | ((i & 1) << i));
            at_neg(2);
            check(shared_oe, 1 << i);
            check(shared_o & (1 << i), (i & 1) << i);
            wr(serial2_pkg::OFF_GPIO, 32'h0);
            wr(serial2_pkg::OFF_CFG, 32'h0);
        end
        conclude();
    end
endmodule
`default_nettype wire
